// ==== shared/xfer_master_pkg.sv ====
/*
  constants and types for the parallel backplane bus master: timing counts
  at a 250 MHz clock, bus widths, command kinds and master states.
  assumes the including design runs on one 4 ns clock.
*/
package xfer_master_pkg;

  localparam int CLK_PERIOD_NS     = 4;
  localparam int ADDR_W            = 16;
  localparam int DATA_W            = 16;
  localparam int IRQ_W             = 8;

  // --------------------------------------------------------------------
  // bus timing, printed figures and derived cycle counts
  // --------------------------------------------------------------------
  localparam int ADDR_SETUP_NS     = 50;
  localparam int ADDR_HOLD_NS      = 50;
  localparam int CMD_WIDTH_NS      = 100;
  localparam int ACK_RELEASE_NS    = 100;
  localparam int ACK_TIMEOUT_MS    = 10;
  localparam int SETUP_CYC   = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC    = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_CYC     = (CMD_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = ACK_RELEASE_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_CYC = ACK_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  localparam int CNT_W             = 8;

  // --------------------------------------------------------------------
  // command kinds and states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_MEM_RD = 2'h0,
    CMD_MEM_WR = 2'h1,
    CMD_IO_RD  = 2'h2,
    CMD_IO_WR  = 2'h3
  } cmd_kind_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_CMD   = 5'h04,
    ST_HOLD  = 5'h08,
    ST_DONE  = 5'h10
  } mst_state_t;

endpackage

// ==== hdl/xfer_master.sv ====
/*
  bus master for single read/write transfers on an active-low parallel
  backplane: drives address, data and four command strobes, waits for the
  slave acknowledge and returns read data through a two-entry buffer.
  assumes the slave side pins are asynchronous and wired open-collector or
  three-state by the surrounding testbench or pad ring.
*/
`timescale 1ns/1ns
module xfer_master
  import xfer_master_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // user request side
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire cmd_kind_t         req_kind_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              req_byte_i,
  input  wire logic              timeout_en_i,
  // user answer side
  output logic                   rsp_valid_o,
  input  wire logic              rsp_ready_i,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic                   rsp_timeout_o,
  output logic                   rsp_early_o,
  // interrupt summary
  output logic                   irq_pending_o,
  output logic [2:0]             irq_top_o,
  // bus pins, active low except the active-high output enables
  output logic [ADDR_W-1:0]      addr_lines_n_o,
  output logic                   addr_lines_oe_o,
  input  wire logic [DATA_W-1:0] data_lines_n_i,
  output logic [DATA_W-1:0]      data_lines_n_o,
  output logic                   data_lines_oe_o,
  output logic                   mem_read_strobe_n_o,
  output logic                   mem_write_strobe_n_o,
  output logic                   port_read_strobe_n_o,
  output logic                   port_write_strobe_n_o,
  output logic                   cmd_oe_o,
  input  wire logic              transfer_ack_n_i,
  input  wire logic              early_ack_n_i,
  input  wire logic [IRQ_W-1:0]  irq_lines_n_i
);

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic             ack_s1_ff, ack_ff, eack_s1_ff, eack_ff;
  logic [DATA_W-1:0] dat_s1_ff, dat_ff;
  logic [IRQ_W-1:0] irq_s1_ff, irq_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_ff  <= 1'b0;
      ack_ff     <= 1'b0;
      eack_s1_ff <= 1'b0;
      eack_ff    <= 1'b0;
      dat_s1_ff  <= '0;
      dat_ff     <= '0;
      irq_s1_ff  <= '0;
      irq_ff     <= '0;
    end else begin
      // inverted on entry so inside logic is active high
      ack_s1_ff  <= ~transfer_ack_n_i;
      ack_ff     <= ack_s1_ff;
      eack_s1_ff <= ~early_ack_n_i;
      eack_ff    <= eack_s1_ff;
      dat_s1_ff  <= ~data_lines_n_i;
      dat_ff     <= dat_s1_ff;
      irq_s1_ff  <= ~irq_lines_n_i;
      irq_ff     <= irq_s1_ff;
    end
  end

  // ------------------------------------------------------------------
  // interrupt priority, line 0 wins
  // ------------------------------------------------------------------
  logic [2:0] top;
  always_comb begin
    top = 3'h0;
    for (int i = IRQ_W - 1; i >= 0; i--) begin
      if (irq_ff[i]) begin
        top = 3'(i);
      end
    end
  end

  logic [2:0] irq_top_ff;
  logic       irq_pend_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_top_ff  <= 3'h0;
      irq_pend_ff <= 1'b0;
    end else begin
      irq_top_ff  <= top;
      irq_pend_ff <= |irq_ff;
    end
  end
  assign irq_top_o     = irq_top_ff;
  assign irq_pending_o = irq_pend_ff;

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  mst_state_t        state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic [31:0]       wait_ff;
  cmd_kind_t         kind_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;
  logic              tmo_ff, early_ff, buf_ready;
  logic              is_rd, is_wr, cmd_on, to_hit;

  assign is_rd  = (kind_ff == CMD_MEM_RD) || (kind_ff == CMD_IO_RD);
  assign is_wr  = ~is_rd;
  assign cmd_on = (state_ff == ST_CMD);
  assign to_hit = timeout_en_i && (wait_ff >= 32'(TIMEOUT_CYCLES));
  assign req_ready_o = (state_ff == ST_IDLE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      wait_ff  <= '0;
      kind_ff  <= CMD_MEM_RD;
      addr_ff  <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      tmo_ff   <= 1'b0;
      early_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (req_valid_i) begin
            kind_ff  <= req_kind_i;
            addr_ff  <= req_addr_i;
            wdata_ff <= req_byte_i ? {8'h00, req_wdata_i[7:0]} : req_wdata_i;
            cnt_ff   <= '0;
            tmo_ff   <= 1'b0;
            early_ff <= 1'b0;
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(SETUP_CYC - 1)) begin
            cnt_ff   <= '0;
            wait_ff  <= '0;
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cnt_ff != CNT_W'(CMD_CYC)) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
          wait_ff <= wait_ff + 1'b1;
          if (eack_ff) begin
            early_ff <= 1'b1;
          end
          // finish on the real acknowledge or the timeout, and after min width
          if ((ack_ff || to_hit) && cnt_ff >= CNT_W'(CMD_CYC)) begin
            rdata_ff <= dat_ff;
            tmo_ff   <= ~ack_ff;
            cnt_ff   <= '0;
            state_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_ff <= cnt_ff + 1'b1;
          // wait out ack release too so the next strobe is clean
          if (cnt_ff >= CNT_W'(HOLD_CYC - 1) && !ack_ff) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (buf_ready) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // bus drive, all pins registered
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_n_ff;
  logic [DATA_W-1:0] data_n_ff;
  logic [3:0]        strb_n_ff;
  logic              addr_oe_ff, data_oe_ff;
  logic              drive;

  assign drive = (state_ff != ST_IDLE) && (state_ff != ST_DONE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_n_ff  <= '1;
      data_n_ff  <= '1;
      strb_n_ff  <= 4'hf;
      addr_oe_ff <= 1'b0;
      data_oe_ff <= 1'b0;
    end else begin
      addr_n_ff  <= ~addr_ff;
      data_n_ff  <= ~wdata_ff;
      addr_oe_ff <= drive;
      data_oe_ff <= drive && is_wr;
      strb_n_ff  <= 4'hf;
      // strobe stays until the same condition that ends the command state
      if (cmd_on && !((ack_ff || to_hit) && cnt_ff >= CNT_W'(CMD_CYC))) begin
        strb_n_ff[kind_ff] <= 1'b0;
      end
    end
  end

  assign addr_lines_n_o        = addr_n_ff;
  assign addr_lines_oe_o       = addr_oe_ff;
  assign data_lines_n_o        = data_n_ff;
  assign data_lines_oe_o       = data_oe_ff;
  assign mem_read_strobe_n_o   = strb_n_ff[CMD_MEM_RD];
  assign mem_write_strobe_n_o  = strb_n_ff[CMD_MEM_WR];
  assign port_read_strobe_n_o  = strb_n_ff[CMD_IO_RD];
  assign port_write_strobe_n_o = strb_n_ff[CMD_IO_WR];
  assign cmd_oe_o              = addr_oe_ff;

  // ------------------------------------------------------------------
  // two-entry answer buffer so a stalled consumer loses nothing
  // ------------------------------------------------------------------
  logic [DATA_W+1:0] buf_mem [2];
  logic              wr_ptr_ff, rd_ptr_ff;
  logic [1:0]        cnt2_ff;
  logic              push, pop;

  assign buf_ready = (cnt2_ff != 2'h2);
  assign push      = (state_ff == ST_DONE) && buf_ready;
  assign pop       = rsp_valid_o && rsp_ready_i;
  assign rsp_valid_o = (cnt2_ff != 2'h0);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff  <= 1'b0;
      rd_ptr_ff  <= 1'b0;
      cnt2_ff    <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr_ff] <= {early_ff, tmo_ff, is_rd ? rdata_ff : {DATA_W{1'b0}}};
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      cnt2_ff <= cnt2_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  assign rsp_rdata_o   = buf_mem[rd_ptr_ff][DATA_W-1:0];
  assign rsp_timeout_o = buf_mem[rd_ptr_ff][DATA_W];
  assign rsp_early_o   = buf_mem[rd_ptr_ff][DATA_W+1];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  logic [3:0] strb_on;
  assign strb_on = ~strb_n_ff;

  one_strobe_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $onehot0(strb_on)) else $error("more than one strobe");
  addr_setup_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(|strb_on) |-> $past(addr_oe_ff, SETUP_CYC)) else $error("address setup short");
  strobe_width_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(|strb_on) |-> (|strb_on)[*8]) else $error("strobe too narrow");
  addr_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(|strb_on) |-> addr_oe_ff[*8] ##1 addr_oe_ff[*5]) else $error("address hold short");
  wdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(|strb_on) && data_oe_ff |-> data_oe_ff[*8] ##1 data_oe_ff[*5])
    else $error("write data hold short");
  no_read_drive_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (strb_on[CMD_MEM_RD] || strb_on[CMD_IO_RD]) |-> !data_oe_ff)
    else $error("master drives data on read");
  done_cause_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_ff == ST_CMD && to_hit && cnt_ff >= CNT_W'(CMD_CYC)
    |=> state_ff == ST_HOLD && strb_on == 4'h0) else $error("timeout did not end command");
  buf_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cnt2_ff <= 2'h2 && !(cnt2_ff == 2'h2 && push)) else $error("buffer overflow");
  read_capture_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_ff == ST_CMD ##1 state_ff == ST_HOLD && !tmo_ff |-> rdata_ff == $past(dat_ff))
    else $error("read data not captured at ack");

  rd_cov: cover property (@(posedge ref_clk_i) $fell(mem_read_strobe_n_o));
  wr_cov: cover property (@(posedge ref_clk_i) $fell(port_write_strobe_n_o));
  full_cov: cover property (@(posedge ref_clk_i) cnt2_ff == 2'h2);
  early_cov: cover property (@(posedge ref_clk_i) push && early_ff);

endmodule

// ==== tb/bus_slave_model.sv ====
/*
  slave model for the transfer master: memory and port words, acknowledge
  after a set delay, early ack on request in memory cycles only, wire timing faults counted.
  assumes the master's clock and pull-ups on every released line.
*/
`timescale 1ns/1ns
module bus_slave_model
  import xfer_master_pkg::*;
(
  // controls
  input  wire logic              clk_i,
  input  wire logic [7:0]        ack_dly_i,
  input  wire logic              ack_off_i,
  input  wire logic              early_on_i,
  // bus, active low except the active-high data enable, then the fault count
  input  wire logic [ADDR_W-1:0] addr_n_i,
  input  wire logic [DATA_W-1:0] mdata_n_i,
  input  wire logic              mdata_oe_i,
  input  wire logic [3:0]        strobe_n_i,
  output logic [DATA_W-1:0]      data_n_o,
  output logic                   ack_n_o,
  output logic                   early_n_o,
  output int                     viol_o
);
  logic [DATA_W-1:0] mem_ff [16];
  logic [DATA_W-1:0] prt_ff [16];
  logic [ADDR_W-1:0] last_a;
  logic [DATA_W-1:0] last_d;
  int                wait_n = 0, width_n = 0, stable_n = 0, hold_n = 999;
  wire  [3:0]        act = ~strobe_n_i;
  wire  [3:0]        idx = ~addr_n_i[3:0];
  initial viol_o = 0;
  initial {ack_n_o, early_n_o} = 2'b11;
  // ----------------------------------------
  // read word only while a read strobe stands
  // ----------------------------------------
  assign data_n_o = mdata_oe_i ? mdata_n_i : act[0] ? ~mem_ff[idx] :
                    act[2] ? ~prt_ff[idx] : 16'hffff;
  // ----------------------------------------
  // acknowledge, write capture, wire timing
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (act != 4'h0) begin
      if (width_n == 0 && ($countones(act) != 1 ||
          (stable_n + 1) * CLK_PERIOD_NS < ADDR_SETUP_NS))
        viol_o++;
      // a long delay also stands for a slave that must outwait an inhibited one
      // ack stays possible after the delay so a late enable still answers
      if (wait_n >= int'(ack_dly_i) && !ack_off_i) begin
        if (act[1]) mem_ff[idx] = ~mdata_n_i;
        if (act[3]) prt_ff[idx] = ~mdata_n_i;
        ack_n_o <= 1'b0;
      end
      early_n_o <= !(early_on_i && act[1:0] != 2'b00);
      width_n++;
      wait_n++;
      hold_n = 0;
    end else begin
      if (width_n != 0 && width_n * CLK_PERIOD_NS < CMD_WIDTH_NS) viol_o++;
      ack_n_o <= 1'b1;
      early_n_o <= 1'b1;
      width_n = 0;
      wait_n = 0;
      hold_n++;
    end
    if (addr_n_i != last_a || (mdata_oe_i && mdata_n_i != last_d)) begin
      if ((hold_n - 1) * CLK_PERIOD_NS < ADDR_HOLD_NS) viol_o++;
      stable_n = 0;
    end else stable_n++;
    last_a = addr_n_i;
    last_d = mdata_n_i;
  end
endmodule

// ==== tb/system_bus_slave_transfer_tb_top.sv ====
/*
  testbench for the backplane transfer master, one task per scenario.
  assumes the slave model on the bus side and a 250 MHz clock.
*/
`timescale 1ns/1ns
module system_bus_slave_transfer_tb_top;
  import xfer_master_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              req_valid_i = 1'b0;
  cmd_kind_t         req_kind_i = CMD_MEM_RD;
  logic [ADDR_W-1:0] req_addr_i = 16'h0000;
  logic [DATA_W-1:0] req_wdata_i = 16'h0000;
  logic              req_byte_i = 1'b0;
  logic              timeout_en_i = 1'b0;
  logic              rsp_ready_i = 1'b0;
  logic [IRQ_W-1:0]  irq_lines_n_i = 8'hff;
  logic [7:0]        ack_dly = 8'h00;
  logic              ack_off = 1'b0;
  logic              early_on = 1'b0;
  logic              req_ready_o, rsp_valid_o, rsp_timeout_o, rsp_early_o, irq_pending_o;
  logic              addr_oe, data_oe, cmd_oe_o, transfer_ack_n_i, early_ack_n_i;
  logic              mem_rd_n, mem_wr_n, port_rd_n, port_wr_n;
  logic [2:0]        irq_top_o;
  logic [DATA_W-1:0] rsp_rdata_o, data_lines_n_i, data_lines_n_o;
  logic [ADDR_W-1:0] addr_lines_n_o;
  int                n_errors = 0;
  int                compares = 0;
  int                viol;
  wire  [3:0]        strobes = cmd_oe_o ? {port_wr_n, port_rd_n, mem_wr_n, mem_rd_n} : 4'hf;
  wire  [ADDR_W-1:0] abus = addr_oe ? addr_lines_n_o : 16'hffff;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // short timeout keeps the no-ack case brief
  xfer_master #(.TIMEOUT_CYCLES(200)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_kind_i(req_kind_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_byte_i(req_byte_i), .timeout_en_i(timeout_en_i),
    .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_rdata_o(rsp_rdata_o),
    .rsp_timeout_o(rsp_timeout_o), .rsp_early_o(rsp_early_o),
    .irq_pending_o(irq_pending_o), .irq_top_o(irq_top_o),
    .addr_lines_n_o(addr_lines_n_o), .addr_lines_oe_o(addr_oe),
    .data_lines_n_i(data_lines_n_i), .data_lines_n_o(data_lines_n_o),
    .data_lines_oe_o(data_oe), .mem_read_strobe_n_o(mem_rd_n),
    .mem_write_strobe_n_o(mem_wr_n), .port_read_strobe_n_o(port_rd_n),
    .port_write_strobe_n_o(port_wr_n), .cmd_oe_o(cmd_oe_o),
    .transfer_ack_n_i(transfer_ack_n_i), .early_ack_n_i(early_ack_n_i),
    .irq_lines_n_i(irq_lines_n_i));
  bus_slave_model u_slave (
    .clk_i(ref_clk_i), .ack_dly_i(ack_dly), .ack_off_i(ack_off), .early_on_i(early_on),
    .addr_n_i(abus), .mdata_n_i(data_lines_n_o), .mdata_oe_i(data_oe), .strobe_n_i(strobes),
    .data_n_o(data_lines_n_i), .ack_n_o(transfer_ack_n_i), .early_n_o(early_ack_n_i),
    .viol_o(viol));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    check("slave wire faults", 16'h0000, viol[15:0]);
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic probe(int w);
    if (w == 0) return req_ready_o;
    if (w == 1) return rsp_valid_o;
    return strobes != 4'hf;
  endfunction
  task automatic await(int w);
    for (int n = 0; probe(w) !== 1'b1; n++) begin
      if (n == 3000) begin
        n_errors++;
        $display("MISMATCH wait %0d expected done seen timeout", w);
        end_of_test();
      end
      @(negedge ref_clk_i);
    end
  endtask
  task automatic send(cmd_kind_t k, logic [15:0] a, logic [15:0] d, logic b);
    await(0);
    req_valid_i = 1'b1;
    req_kind_i = k;
    req_addr_i = a;
    req_wdata_i = d;
    req_byte_i = b;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    await(2);
    check("strobes", ~(16'h0001 << k), {12'hfff, strobes});
    check("address", ~a, abus);
    if (k inside {CMD_MEM_WR, CMD_IO_WR})
      check("write data", b ? {8'hff, ~d[7:0]} : ~d, data_lines_n_o);
    check("data drive", {15'h0, k inside {CMD_MEM_WR, CMD_IO_WR}}, {15'h0, data_oe});
  endtask
  task automatic recv(logic [15:0] d, logic tmo, logic early);
    @(negedge ref_clk_i);
    await(1);
    check("read data", d, rsp_rdata_o);
    check("timeout flag", {15'h0, tmo}, {15'h0, rsp_timeout_o});
    check("early flag", {15'h0, early}, {15'h0, rsp_early_o});
    rsp_ready_i = 1'b1;
    @(negedge ref_clk_i);
    rsp_ready_i = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_four_kinds();
    send(CMD_MEM_WR, 16'h1003, 16'ha55a, 1'b0);
    recv(16'h0000, 1'b0, 1'b0);
    send(CMD_IO_WR, 16'h0003, 16'h1234, 1'b0);
    recv(16'h0000, 1'b0, 1'b0);
    send(CMD_MEM_RD, 16'h1003, 16'h0000, 1'b0);
    recv(16'ha55a, 1'b0, 1'b0);
    send(CMD_IO_RD, 16'h0003, 16'h0000, 1'b0);
    recv(16'h1234, 1'b0, 1'b0);
  endtask
  task automatic t_slow_byte_early();
    ack_dly = 8'h3c;
    send(CMD_MEM_WR, 16'h0007, 16'hbeef, 1'b1);
    recv(16'h0000, 1'b0, 1'b0);
    early_on = 1'b1;
    send(CMD_MEM_RD, 16'h0007, 16'h0000, 1'b0);
    recv(16'h00ef, 1'b0, 1'b1);
    send(CMD_IO_RD, 16'h0003, 16'h0000, 1'b0);
    recv(16'h1234, 1'b0, 1'b0);
    early_on = 1'b0;
    ack_dly = 8'h00;
  endtask
  task automatic t_no_ack();
    ack_off = 1'b1;
    timeout_en_i = 1'b1;
    send(CMD_MEM_RD, 16'h1003, 16'h0000, 1'b0);
    // the slave still drives its word on the bus when the strobe is cut
    recv(16'ha55a, 1'b1, 1'b0);
    timeout_en_i = 1'b0;
    send(CMD_MEM_RD, 16'h1003, 16'h0000, 1'b0);
    for (int n = 0; n < 400 && rsp_valid_o === 1'b0; n++) @(negedge ref_clk_i);
    check("answer without ack", 16'h0000, {15'h0, rsp_valid_o});
    ack_off = 1'b0;
    recv(16'ha55a, 1'b0, 1'b0);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 9; i++) begin
      irq_lines_n_i = (i == 8) ? 8'hff : ~(8'hff << i);
      for (int n = 0; n < 20 && irq_top_o !== i[2:0]; n++) @(negedge ref_clk_i);
      repeat (4) @(negedge ref_clk_i);
      if (i < 8) check("irq top", 16'(i), {13'h0, irq_top_o});
      check("irq pending", {15'h0, i < 8}, {15'h0, irq_pending_o});
    end
  endtask
  task automatic t_buffer_full();
    for (int i = 0; i < 3; i++) send(CMD_MEM_WR, 16'h1008 + i, 16'h0011 * i, 1'b0);
    repeat (200) @(negedge ref_clk_i);
    check("ready with buffer full", 16'h0000, {15'h0, req_ready_o});
    for (int i = 0; i < 3; i++) recv(16'h0000, 1'b0, 1'b0);
    check("drained", 16'h0000, {15'h0, rsp_valid_o});
    send(CMD_MEM_RD, 16'h100a, 16'h0000, 1'b0);
    recv(16'h0022, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    check("idle strobes", 16'hffff, {12'hfff, strobes});
    t_four_kinds();
    t_slow_byte_early();
    t_no_ack();
    t_irq();
    t_buffer_full();
    end_of_test();
  end
endmodule
